// *** shared/cidr_pkg.sv ***
package cidr_pkg;
  // Register offsets
  localparam logic [7:0] OFS_INPUT_SOURCE = 8'h00;
  localparam logic [7:0] OFS_DATA_LINE = 8'h01;
  localparam logic [7:0] OFS_ADC_DETECT = 8'h02;
  localparam logic [7:0] OFS_LAST = 8'h02;
  // Power-on values
  localparam logic [7:0] RST_INPUT_SOURCE = 8'h48;
  localparam logic [7:0] RST_DATA_LINE = 8'h01;
  localparam logic [7:0] RST_ADC_DETECT = 8'h19;
  // Bits restored by a watchdog expiry
  localparam logic [7:0] WDM_INPUT_SOURCE = 8'hC0;
  localparam logic [7:0] WDM_DATA_LINE = 8'h00;
  localparam logic [7:0] WDM_ADC_DETECT = 8'hE2;
  // Bits that hold storage; the rest read as zero
  localparam logic [7:0] STM_DATA_LINE = 8'hFD;
  localparam logic [7:0] STM_ADC_DETECT = 8'hFB;
  // Field positions
  localparam int HIZ_BIT = 7;
  localparam int LIM_BIT = 6;
  localparam int ICL_MSB = 5;
  localparam int DP_MSB = 7;
  localparam int DP_LSB = 5;
  localparam int DM_MSB = 4;
  localparam int DM_LSB = 2;
  localparam int VOS_BIT = 0;
  localparam int GO_BIT = 7;
  localparam int RATE_BIT = 6;
  localparam int FREQ_BIT = 5;
  localparam int ICO_BIT = 4;
  localparam int HVDCP_BIT = 3;
  localparam int FORCE_BIT = 1;
  localparam int AUTO_BIT = 0;
  // Scaling
  localparam logic [11:0] ICL_BASE_MA = 12'h064;
  localparam logic [11:0] ICL_STEP_MA = 12'h032;
  localparam logic [9:0] VOS_LOW_MV = 10'h190;
  localparam logic [9:0] VOS_HIGH_MV = 10'h258;
  localparam logic [2:0] DRIVE_RESERVED = 3'h7;
  // Timing
  localparam int CLK_FREQ_KHZ = 125000;
  localparam int ADC_PERIOD_MS = 1000;
  localparam int ADC_PERIOD_CYC = ADC_PERIOD_MS * CLK_FREQ_KHZ;
  // Two-wire slave address, value arbitrary
  localparam logic [6:0] SLAVE_ADDR = 7'h2C;
endpackage : cidr_pkg

// *** shared/cidr_reg_if.sv ***
`timescale 1ns/1ps
interface cidr_reg_if;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  modport link (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
  modport bank (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface : cidr_reg_if

// *** rtl/cidr_i2c_slave.sv ***
`timescale 1ns/1ps
module cidr_i2c_slave import cidr_pkg::*; #(
  parameter logic [6:0] DEV_ADDR = SLAVE_ADDR
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Two-wire pins
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  // Register side
  cidr_reg_if.link bus
);
  typedef enum logic [2:0] {st_idle, st_dev, st_ptr, st_wr, st_rd} cidr_st_t;

  logic [1:0] scl_sync_reg, sda_sync_reg;
  logic scl_d_reg, sda_d_reg;
  cidr_st_t state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] shift_reg, shift_next, ptr_reg, ptr_next;
  logic oe_reg, oe_next, wr_en_reg, wr_en_next;
  logic [7:0] wr_addr_reg, wr_addr_next, wr_data_reg, wr_data_next;
  logic ack;

  wire scl = scl_sync_reg[1];
  wire sda = sda_sync_reg[1];
  wire start_cond = scl & scl_d_reg & sda_d_reg & ~sda;
  wire stop_cond = scl & scl_d_reg & ~sda_d_reg & sda;
  wire scl_rise = scl & ~scl_d_reg;
  wire scl_fall = ~scl & scl_d_reg;
  wire receiving = (state_reg == st_dev) | (state_reg == st_ptr) |
                   (state_reg == st_wr);

  assign bus.wr_en = wr_en_reg;
  assign bus.wr_addr = wr_addr_reg;
  assign bus.wr_data = wr_data_reg;
  assign bus.rd_addr = ptr_reg;
  assign o_sda_oe = oe_reg;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    shift_next = shift_reg;
    ptr_next = ptr_reg;
    oe_next = oe_reg;
    wr_en_next = 1'b0;
    wr_addr_next = wr_addr_reg;
    wr_data_next = wr_data_reg;
    ack = 1'b0;
    if (start_cond) begin
      state_next = st_dev;
      // The SCL fall that follows START wraps the count to zero
      cnt_next = 4'hF;
      oe_next = 1'b0;
    end else if (stop_cond) begin
      state_next = st_idle;
      oe_next = 1'b0;
    end else if (state_reg != st_idle) begin
      if (scl_rise && receiving && cnt_reg < 4'h8) begin
        shift_next = {shift_reg[6:0], sda};
      end
      // Master refuses the next byte
      if (scl_rise && state_reg == st_rd && cnt_reg == 4'h8 && sda) begin
        state_next = st_idle;
      end
      if (scl_fall && cnt_reg == 4'h8) begin
        oe_next = 1'b0;
        cnt_next = 4'h0;
        if (state_reg == st_ptr) begin
          ptr_next = shift_reg;
          state_next = st_wr;
        end else if ((state_reg == st_dev && shift_reg[0]) ||
                     state_reg == st_rd) begin
          state_next = st_rd;
          if (ptr_reg > OFS_LAST) begin
            state_next = st_idle;
          end else begin
            shift_next = bus.rd_data;
            oe_next = ~bus.rd_data[7];
            ptr_next = ptr_reg + 8'h01;
          end
        end else if (state_reg == st_dev) begin
          state_next = st_ptr;
        end
      end else if (scl_fall && cnt_reg == 4'h7) begin
        cnt_next = 4'h8;
        unique case (state_reg)
          st_dev: ack = (shift_reg[7:1] == DEV_ADDR);
          st_ptr: ack = (shift_reg <= OFS_LAST);
          st_wr: ack = (ptr_reg <= OFS_LAST);
          st_rd: ack = 1'b0;
          st_idle: ack = 1'b0;
        endcase
        if (state_reg == st_wr && ack) begin
          wr_en_next = 1'b1;
          wr_addr_next = ptr_reg;
          wr_data_next = shift_reg;
          ptr_next = ptr_reg + 8'h01;
        end
        // Undefined offset or foreign address: answer not-acknowledge
        oe_next = ack;
        if (!ack && state_reg != st_rd) begin
          state_next = st_idle;
        end
      end else if (scl_fall) begin
        cnt_next = cnt_reg + 4'h1;
        if (state_reg == st_rd) begin
          shift_next = {shift_reg[6:0], 1'b0};
          oe_next = ~shift_reg[6];
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      state_reg <= st_idle;
      cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg <= 8'h00;
      oe_reg <= 1'b0;
      o_sda_out <= 1'b0;
      wr_en_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      wr_data_reg <= 8'h00;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], i_scl};
      sda_sync_reg <= {sda_sync_reg[0], i_sda};
      scl_d_reg <= scl;
      sda_d_reg <= sda;
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      shift_reg <= shift_next;
      ptr_reg <= ptr_next;
      oe_reg <= oe_next;
      o_sda_out <= 1'b0;
      wr_en_reg <= wr_en_next;
      wr_addr_reg <= wr_addr_next;
      wr_data_reg <= wr_data_next;
    end
  end
endmodule : cidr_i2c_slave

// *** rtl/cidr_charger_input_regs.sv ***
`timescale 1ns/1ps
module cidr_charger_input_regs import cidr_pkg::*; #(
  parameter int unsigned ADC_PERIOD_CYCLES = ADC_PERIOD_CYC
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Two-wire register bus
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  // Analog and detection status
  input wire logic i_vbus_present,
  input wire logic i_detect_busy,
  input wire logic [5:0] i_detect_limit_code,
  input wire logic i_dcp_found,
  input wire logic i_adc_busy,
  // Reset sources on the device clock
  input wire logic i_register_reset,
  input wire logic i_watchdog_expiry,
  // Controls
  output logic o_high_impedance_enable,
  output logic o_limit_pin_enable,
  output logic [11:0] o_input_current_limit_ma,
  output logic [6:0] o_positive_line_drive_sel,
  output logic [6:0] o_negative_line_drive_sel,
  output logic [9:0] o_input_voltage_limit_offset_mv,
  output logic o_adc_continuous_select,
  output logic o_otg_switching_freq_select,
  output logic o_input_current_optimizer_on,
  // Event pulses
  output logic o_adc_start,
  output logic o_port_detect_go,
  output logic o_high_volt_handshake_go
);
  localparam int TW = $clog2(ADC_PERIOD_CYCLES + 1);
  localparam int SW = 10;
  if (ADC_PERIOD_CYCLES < 1) begin : g_check
    $error("ADC_PERIOD_CYCLES must be at least one");
  end
  cidr_reg_if rif ();
  logic [1:0] rst_pipe_reg;
  logic [SW-1:0] sync1_reg, sync2_reg;
  logic [2:0] prev_reg;
  logic [7:0] r0_reg, r0_next, r1_reg, r1_next, r2_reg, r2_next;
  logic override_reg, override_next, det_seen_reg, det_seen_next;
  logic [TW-1:0] timer_reg, timer_next;
  //////////////////////////////////////////////////////////////////////////
  // Reset release and input synchronisers
  wire rst_n = rst_pipe_reg[1];
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_pipe_reg <= 2'h0;
    end else begin
      rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
    end
  end
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg <= 3'h0;
    end else begin
      sync1_reg <= {i_vbus_present, i_detect_busy, i_adc_busy, i_dcp_found,
                    i_detect_limit_code};
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg[SW-1:SW-3];
    end
  end
  wire vbus_s = sync2_reg[9];
  wire det_busy_s = sync2_reg[8];
  wire adc_busy_s = sync2_reg[7];
  wire dcp_s = sync2_reg[6];
  wire [5:0] det_code_s = sync2_reg[5:0];
  wire plug_rise = vbus_s & ~prev_reg[2];
  wire det_done = ~det_busy_s & prev_reg[1];
  wire adc_done = ~adc_busy_s & prev_reg[0];
  //////////////////////////////////////////////////////////////////////////
  // Bus slave and register decode
  cidr_i2c_slave u_slave (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .o_sda_out(o_sda_out),
    .o_sda_oe(o_sda_oe),
    .bus(rif.link)
  );
  wire wr0 = rif.wr_en & (rif.wr_addr == OFS_INPUT_SOURCE);
  wire wr1 = rif.wr_en & (rif.wr_addr == OFS_DATA_LINE);
  wire wr2 = rif.wr_en & (rif.wr_addr == OFS_ADC_DETECT);
  wire [7:0] wd = rif.wr_data;
  wire go_busy = r2_reg[GO_BIT] | adc_busy_s | det_busy_s;
  wire [7:0] r2_read = {go_busy, r2_reg[6:0]};
  wire icl_write_ok = wr0 & ~det_busy_s;
  wire tick = r2_reg[RATE_BIT] & (timer_reg == '0);

  assign rif.rd_data = (rif.rd_addr == OFS_INPUT_SOURCE) ? r0_reg :
                       (rif.rd_addr == OFS_DATA_LINE) ? r1_reg :
                       (rif.rd_addr == OFS_ADC_DETECT) ? r2_read : 8'h00;
  //////////////////////////////////////////////////////////////////////////
  // Register next values
  always_comb begin
    r0_next = r0_reg;
    override_next = override_reg;
    det_seen_next = det_seen_reg | det_done;
    if (wr0) r0_next[HIZ_BIT:LIM_BIT] = wd[HIZ_BIT:LIM_BIT];
    if (icl_write_ok) begin
      r0_next[ICL_MSB:0] = wd[ICL_MSB:0];
      override_next = override_reg | det_seen_reg;
    end
    if (det_done && !override_reg) r0_next[ICL_MSB:0] = det_code_s;
    if (plug_rise) begin
      r0_next[HIZ_BIT] = RST_INPUT_SOURCE[HIZ_BIT];
      override_next = 1'b0;
      det_seen_next = 1'b0;
    end
    r1_next = wr1 ? (wd & STM_DATA_LINE) : r1_reg;
    r2_next = r2_reg;
    if (adc_done) r2_next[GO_BIT] = 1'b0;
    if (det_done) r2_next[FORCE_BIT] = 1'b0;
    if (wr2) begin
      r2_next[6:3] = wd[6:3];
      r2_next[AUTO_BIT] = wd[AUTO_BIT];
      if (wd[GO_BIT] && !r2_reg[RATE_BIT]) begin
        r2_next[GO_BIT] = 1'b1;
      end
      if (wd[FORCE_BIT]) r2_next[FORCE_BIT] = 1'b1;
    end
    if (i_watchdog_expiry) begin
      r0_next = (r0_next & ~WDM_INPUT_SOURCE) |
                (RST_INPUT_SOURCE & WDM_INPUT_SOURCE);
      r1_next = (r1_next & ~WDM_DATA_LINE) | (RST_DATA_LINE & WDM_DATA_LINE);
      r2_next = (r2_next & ~WDM_ADC_DETECT) |
                (RST_ADC_DETECT & WDM_ADC_DETECT);
    end
    if (i_register_reset) begin
      r0_next = RST_INPUT_SOURCE;
      r1_next = RST_DATA_LINE;
      r2_next = RST_ADC_DETECT;
      override_next = 1'b0;
    end
  end
  assign timer_next = !r2_reg[RATE_BIT] ? '0 :
                      tick ? TW'(ADC_PERIOD_CYCLES - 1) :
                      timer_reg - TW'(1);
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      r0_reg <= RST_INPUT_SOURCE;
      r1_reg <= RST_DATA_LINE;
      r2_reg <= RST_ADC_DETECT;
      override_reg <= 1'b0;
      det_seen_reg <= 1'b0;
      timer_reg <= '0;
    end else begin
      r0_reg <= r0_next;
      r1_reg <= r1_next;
      r2_reg <= r2_next;
      override_reg <= override_next;
      det_seen_reg <= det_seen_next;
      timer_reg <= timer_next;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // Registered outputs
  function automatic logic [6:0] drive_sel(input logic [2:0] code);
    drive_sel = (code == DRIVE_RESERVED) ? 7'h00 : 7'h01 << code;
  endfunction : drive_sel
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_high_impedance_enable <= 1'b0;
      o_limit_pin_enable <= 1'b0;
      o_input_current_limit_ma <= 12'h000;
      o_positive_line_drive_sel <= 7'h00;
      o_negative_line_drive_sel <= 7'h00;
      o_input_voltage_limit_offset_mv <= 10'h000;
      o_adc_continuous_select <= 1'b0;
      o_otg_switching_freq_select <= 1'b0;
      o_input_current_optimizer_on <= 1'b0;
      o_adc_start <= 1'b0;
      o_port_detect_go <= 1'b0;
      o_high_volt_handshake_go <= 1'b0;
    end else begin
      o_high_impedance_enable <= r0_reg[HIZ_BIT];
      o_limit_pin_enable <= r0_reg[LIM_BIT];
      o_input_current_limit_ma <= ICL_BASE_MA +
        ICL_STEP_MA * 12'(r0_reg[ICL_MSB:0]);
      o_positive_line_drive_sel <= drive_sel(r1_reg[DP_MSB:DP_LSB]);
      o_negative_line_drive_sel <= drive_sel(r1_reg[DM_MSB:DM_LSB]);
      o_input_voltage_limit_offset_mv <= r1_reg[VOS_BIT] ? VOS_HIGH_MV :
                                         VOS_LOW_MV;
      o_adc_continuous_select <= r2_reg[RATE_BIT];
      o_otg_switching_freq_select <= r2_reg[FREQ_BIT];
      o_input_current_optimizer_on <= r2_reg[ICO_BIT];
      o_adc_start <= (r2_next[GO_BIT] & ~r2_reg[GO_BIT]) | tick;
      o_port_detect_go <= (r2_next[FORCE_BIT] & ~r2_reg[FORCE_BIT]) |
                          (plug_rise & r2_reg[AUTO_BIT]);
      o_high_volt_handshake_go <= det_done & dcp_s &
                                  r2_reg[HVDCP_BIT];
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_n);
  property p_hiz_plug;
    plug_rise |=> !r0_reg[HIZ_BIT];
  endproperty
  a_hiz_plug: assert property (p_hiz_plug)
    else $error("plug-in left high-impedance enable set");
  property p_icl_scale;
    1'b1 |=> o_input_current_limit_ma ==
      ICL_BASE_MA + ICL_STEP_MA * 12'($past(r0_reg[ICL_MSB:0]));
  endproperty
  a_icl_scale: assert property (p_icl_scale)
    else $error("current limit scaling wrong");
  property p_auto_load;
    det_done && !override_reg && !i_register_reset && !i_watchdog_expiry
      |=> r0_reg[ICL_MSB:0] == $past(det_code_s);
  endproperty
  a_auto_load: assert property (p_auto_load)
    else $error("detection result not loaded");
  property p_override_holds;
    override_reg && !icl_write_ok && !plug_rise && !i_register_reset
      |=> $stable(r0_reg[ICL_MSB:0]);
  endproperty
  a_override_holds: assert property (p_override_holds)
    else $error("host limit overwritten");
  property p_go_locked;
    r2_reg[RATE_BIT] && !r2_reg[GO_BIT] |=> !r2_reg[GO_BIT];
  endproperty
  a_go_locked: assert property (p_go_locked)
    else $error("go bit set in continuous mode");
  property p_go_busy;
    (adc_busy_s || det_busy_s) && rif.rd_addr == OFS_ADC_DETECT
      |-> rif.rd_data[GO_BIT];
  endproperty
  a_go_busy: assert property (p_go_busy)
    else $error("go bit low while busy");
  property p_go_start;
    wr2 && wd[GO_BIT] && !r2_reg[RATE_BIT] && !r2_reg[GO_BIT] &&
      !i_register_reset && !i_watchdog_expiry |=> o_adc_start;
  endproperty
  a_go_start: assert property (p_go_start)
    else $error("write of go did not start conversion");
  property p_periodic;
    r2_reg[RATE_BIT] && timer_reg == '0 |=> o_adc_start ##1 !o_adc_start;
  endproperty
  a_periodic: assert property (p_periodic)
    else $error("continuous conversion tick missing");
  property p_handshake;
    det_done && dcp_s |=> o_high_volt_handshake_go == $past(r2_reg[HVDCP_BIT]);
  endproperty
  a_handshake: assert property (p_handshake)
    else $error("adapter handshake decision wrong");
  sequence s_force_write;
    wr2 && wd[FORCE_BIT] && !r2_reg[FORCE_BIT] && !i_register_reset &&
      !i_watchdog_expiry;
  endsequence
  sequence s_force_held;
    r2_reg[FORCE_BIT] && o_port_detect_go;
  endsequence
  property p_force;
    s_force_write |=> s_force_held;
  endproperty
  a_force: assert property (p_force)
    else $error("forced detection not started");
  property p_auto_detect;
    plug_rise |=> o_port_detect_go == $past(r2_reg[AUTO_BIT]);
  endproperty
  a_auto_detect: assert property (p_auto_detect)
    else $error("auto detection decision wrong");
  property p_reg_reset;
    i_register_reset |=> r0_reg == RST_INPUT_SOURCE &&
      r1_reg == RST_DATA_LINE && r2_reg == RST_ADC_DETECT;
  endproperty
  a_reg_reset: assert property (p_reg_reset)
    else $error("register reset incomplete");
endmodule : cidr_charger_input_regs

// *** bench/cidr_host_model.sv ***
`timescale 1ns/1ps
module cidr_host_model import cidr_pkg::*; #(
  parameter logic [6:0] DEV_ADDR = SLAVE_ADDR
) (
  // Clock and bus wire
  input wire logic i_clk,
  input wire logic i_sda,
  // Driven lines, 1 releases to the pull-up
  output logic o_scl,
  output logic o_sda,
  // Read result
  output logic o_rd_done,
  output logic [7:0] o_rd_data
);
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
    o_rd_done = 1'b0;
    o_rd_data = 8'h00;
  end
  task automatic half();
    repeat (10) @(negedge i_clk);
  endtask : half
  task automatic start();
    o_sda = 1'b1;
    half();
    o_scl = 1'b1;
    half();
    o_sda = 1'b0;
    half();
    o_scl = 1'b0;
    repeat (4) @(negedge i_clk);
  endtask : start
  task automatic stop();
    o_sda = 1'b0;
    half();
    o_scl = 1'b1;
    half();
    o_sda = 1'b1;
    half();
  endtask : stop
  // Data is held past the SCL fall so it is never seen as a start or stop
  task automatic bitx(input logic b, output logic r);
    o_sda = b;
    half();
    o_scl = 1'b1;
    half();
    r = i_sda;
    o_scl = 1'b0;
    repeat (4) @(negedge i_clk);
  endtask : bitx
  task automatic byte_io(input logic [7:0] d, output logic [7:0] q,
                         output logic nk);
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(1'b1, nk);
  endtask : byte_io
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d,
                    output logic [2:0] nk);
    logic [7:0] q;
    start();
    byte_io({DEV_ADDR, 1'b0}, q, nk[2]);
    byte_io(ofs, q, nk[1]);
    byte_io(d, q, nk[0]);
    stop();
  endtask : wr
  task automatic rd(input logic [7:0] ofs);
    logic [7:0] q;
    logic nk;
    start();
    byte_io({DEV_ADDR, 1'b0}, q, nk);
    byte_io(ofs, q, nk);
    start();
    byte_io({DEV_ADDR, 1'b1}, q, nk);
    byte_io(8'hFF, o_rd_data, nk);
    stop();
    o_rd_done = 1'b1;
    @(negedge i_clk);
    o_rd_done = 1'b0;
  endtask : rd
endmodule : cidr_host_model

// *** bench/cidr_charger_input_regs_tb.sv ***
`timescale 1ns/1ps
module cidr_charger_input_regs_tb import cidr_pkg::*;;
  logic clk = 1'b0;
  logic reset_n, scl, sda_m, sda_out, sda_oe, vbus, det_busy, dedicated_charging_port;
  logic adc_busy, reg_rst, wdog, hiz, lim, rate, freq, ico;
  logic adc_go, det_go, hv_go, rd_done;
  logic [5:0] det_code;
  logic [11:0] icl;
  logic [6:0] pos_sel, neg_sel;
  logic [9:0] vos;
  logic [7:0] rd_data, v;
  logic [2:0] cd, nk;
  logic [7:0] exp_q[$];
  int err_count = 0, check_count = 0, n_adc = 0, n_det = 0, n_hv = 0;
  int na, nd, nh;
  integer seed;
  wire sda_line = sda_m & (sda_oe ? sda_out : 1'b1);
  always #4 clk = ~clk;
  cidr_charger_input_regs #(.ADC_PERIOD_CYCLES(20)) cidr_charger_input_regs_i (
    .i_clk(clk), .i_reset_n(reset_n), .i_scl(scl), .i_sda(sda_line),
    .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_vbus_present(vbus),
    .i_detect_busy(det_busy), .i_detect_limit_code(det_code),
    .i_dcp_found(dedicated_charging_port), .i_adc_busy(adc_busy), .i_register_reset(reg_rst),
    .i_watchdog_expiry(wdog), .o_high_impedance_enable(hiz),
    .o_limit_pin_enable(lim), .o_input_current_limit_ma(icl),
    .o_positive_line_drive_sel(pos_sel), .o_negative_line_drive_sel(neg_sel),
    .o_input_voltage_limit_offset_mv(vos), .o_adc_continuous_select(rate),
    .o_otg_switching_freq_select(freq), .o_input_current_optimizer_on(ico),
    .o_adc_start(adc_go), .o_port_detect_go(det_go),
    .o_high_volt_handshake_go(hv_go));
  cidr_host_model cidr_host_model_i (
    .i_clk(clk), .i_sda(sda_line), .o_scl(scl), .o_sda(sda_m),
    .o_rd_done(rd_done), .o_rd_data(rd_data));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic results();
    $display("Checks %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results
  function automatic logic [15:0] lim_ma(input logic [5:0] f);
    return 16'(ICL_BASE_MA) + 16'(ICL_STEP_MA) * 16'(f);
  endfunction : lim_ma
  function automatic logic [15:0] onehot(input logic [2:0] c);
    return (c == DRIVE_RESERVED) ? 16'h0000 : 16'(16'h0001 << c);
  endfunction : onehot
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    cidr_host_model_i.wr(ofs, d, nk);
    check(16'(nk), 16'h0000);
  endtask : wr
  task automatic rd(input logic [7:0] ofs, input logic [7:0] e);
    exp_q.push_back(e);
    cidr_host_model_i.rd(ofs);
  endtask : rd
  // Runs one detection, reading the control register while it is busy
  task automatic detect(input logic [5:0] code, input logic [7:0] e);
    det_code = code;
    det_busy = 1'b1;
    rd(OFS_ADC_DETECT, e);
    det_busy = 1'b0;
    repeat (8) @(negedge clk);
  endtask : detect
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (adc_go === 1'b1) n_adc++;
    if (det_go === 1'b1) n_det++;
    if (hv_go === 1'b1) n_hv++;
    if (rd_done === 1'b1) begin
      if (exp_q.size() == 0) check(16'(rd_data), 16'hFFFF);
      else check(16'(rd_data), 16'(exp_q.pop_front()));
    end
  end
  initial begin
    #600000;
    err_count++;
    $display("[FAIL] %0t run did not finish", $time);
    results();
  end
  initial begin
    seed = 39034;
    reset_n = 1'b0;
    vbus = 1'b0;
    det_busy = 1'b0;
    det_code = 6'h00;
    dedicated_charging_port = 1'b0;
    adc_busy = 1'b0;
    reg_rst = 1'b0;
    wdog = 1'b0;
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    repeat (6) @(negedge clk);
    rd(OFS_INPUT_SOURCE, 8'h48);
    rd(OFS_DATA_LINE, 8'h01);
    rd(OFS_ADC_DETECT, 8'h19);
    check(16'(icl), lim_ma(6'h08));
    check(16'(lim), 16'h0001);
    for (int c = 0; c < 8; c++) begin
      cd = 3'(c);
      wr(OFS_DATA_LINE, {cd, ~cd, 1'b0, cd[0]});
      check(16'(pos_sel), onehot(cd));
      check(16'(neg_sel), onehot(~cd));
      check(16'(vos), 16'(cd[0] ? VOS_HIGH_MV : VOS_LOW_MV));
    end
    wr(OFS_DATA_LINE, 8'hFF);
    for (int k = 0; k < 4; k++) begin
      v = 8'($random(seed));
      wr(OFS_INPUT_SOURCE, v);
      check(16'(icl), lim_ma(v[5:0]));
      check(16'(hiz), 16'(v[7]));
    end
    wr(OFS_INPUT_SOURCE, 8'hBF);
    check(16'(icl), 16'h0CB2);
    nd = n_det;
    vbus = 1'b1;
    repeat (6) @(negedge clk);
    check(16'(hiz), 16'h0000);
    check(16'(n_det - nd), 16'h0001);
    rd(OFS_INPUT_SOURCE, 8'h3F);
    dedicated_charging_port = 1'b1;
    nh = n_hv;
    detect(6'h0A, 8'h99);
    check(16'(icl), lim_ma(6'h0A));
    check(16'(n_hv - nh), 16'h0001);
    wr(OFS_INPUT_SOURCE, 8'h45);
    wr(OFS_ADC_DETECT, 8'h01);
    check(16'(ico), 16'h0000);
    detect(6'h20, 8'h81);
    check(16'(icl), lim_ma(6'h05));
    check(16'(n_hv - nh), 16'h0001);
    nd = n_det;
    wr(OFS_ADC_DETECT, 8'h03);
    check(16'(n_det - nd), 16'h0001);
    rd(OFS_ADC_DETECT, 8'h03);
    detect(6'h01, 8'h83);
    rd(OFS_ADC_DETECT, 8'h01);
    na = n_adc;
    wr(OFS_ADC_DETECT, 8'h81);
    check(16'(n_adc - na), 16'h0001);
    adc_busy = 1'b1;
    wr(OFS_ADC_DETECT, 8'h01);
    rd(OFS_ADC_DETECT, 8'h81);
    adc_busy = 1'b0;
    rd(OFS_ADC_DETECT, 8'h01);
    wr(OFS_ADC_DETECT, 8'h41);
    check(16'(rate), 16'h0001);
    na = n_adc;
    repeat (200) @(negedge clk);
    check(16'(n_adc - na), 16'h000A);
    wr(OFS_ADC_DETECT, 8'hC1);
    rd(OFS_ADC_DETECT, 8'h41);
    wr(OFS_ADC_DETECT, 8'h63);
    check(16'(freq), 16'h0001);
    wr(OFS_INPUT_SOURCE, 8'h85);
    wdog = 1'b1;
    @(negedge clk);
    wdog = 1'b0;
    rd(OFS_INPUT_SOURCE, 8'h45);
    rd(OFS_ADC_DETECT, 8'h01);
    rd(OFS_DATA_LINE, 8'hFD);
    reg_rst = 1'b1;
    @(negedge clk);
    reg_rst = 1'b0;
    rd(OFS_INPUT_SOURCE, 8'h48);
    rd(OFS_DATA_LINE, 8'h01);
    rd(OFS_ADC_DETECT, 8'h19);
    wr(OFS_ADC_DETECT, 8'h18);
    vbus = 1'b0;
    repeat (6) @(negedge clk);
    nd = n_det;
    vbus = 1'b1;
    repeat (6) @(negedge clk);
    check(16'(n_det - nd), 16'h0000);
    cidr_host_model_i.wr(8'h03, 8'h00, nk);
    check(16'(nk), 16'h0003);
    results();
  end
endmodule : cidr_charger_input_regs_tb
